// ---- core/motor_stop_brake_jog_sequencer.v ----
// Functional notes
// R1: Voltage stop steps to intermediate level, then ramps linearly to minimum; default 100%.
// R2: Brake method applies only for brake stop; 0 vector (default), 1 reverse current.
// R3: Vector brake while speed at or above threshold, DC brake below it.
// R4: Forward contactor on in start and run; braking releases it, then reverse contactor. Vector braking keeps it on.
// R5: Reverse relay held off for programmed delay after forward relay drops; 0.5 s default.
// R6: Reverse current braking until speed below threshold, then DC braking.
// R7: DC braking drives second and third phases only, first phase off.
// R8: DC braking ends at standstill, stop timeout, or optional rotation sensor input.
// R9: Stop time bounds every non-coast stop as a timeout; default 10 s, 0-120 s.
// R10: Brake strength percent of braking power; default 75%, range 20-100%.
// R11: DC brake strength percent; default 30%, range 20-80%.
// R12: DC switch speed threshold percent of nominal; default 30%, range 20-80%.
// R13: Jog is requested externally through jog forward or jog reverse inputs.
// R14: Jog in a direction only when that direction is permitted.
// R15: Forward operation relay active while jogging; reversal by vector control only.
// R16: Jog speeds 1-30% of nominal, each default 10%.
// R17: Jog speed ramps toward reference at ramp rate; default 0.2 s/%, 0.1-10 s/%.
// R18: Stop codes 1 linear, 2 square, 3 voltage, 4 coast default, 5 brake. Code 2 ramps linearly, the same as code 1.
// R19: Forward and reverse contactors never on together, even with zero delay.
`timescale 1ns/1ps
`include "stop_seq_defines.vh"

module motor_stop_brake_jog_sequencer #(
	parameter TICK_CYCLES = `TICK_TIME_MS * `CLK_FREQ_KHZ
) (
	// Clock and reset
	input wire MCLK,
	input wire NRST,
	// APB slave
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [7:0] PADDR,
	input wire [31:0] PWDATA,
	output reg PREADY,
	output reg [31:0] PRDATA,
	output reg PSLVERR,
	// Operator and motor feedback
	input wire RUN_CMD,
	input wire JOG_FORWARD_INPUT,
	input wire JOG_REVERSE_INPUT,
	input wire [6:0] SPEED_PCT,
	input wire MOTOR_STOPPED,
	input wire ROT_SENSOR_STOP,
	// Contactors and relays
	output reg FORWARD_RUN_RELAY,
	output reg REVERSE_BRAKE_RELAY,
	output reg FORWARD_OPERATION_RELAY_FN,
	// Power stage
	output reg [6:0] VOLT_LEVEL,
	output reg [2:0] PHASE_EN,
	output reg VECTOR_BRAKE_ACTIVE,
	output reg DC_BRAKE_ACTIVE,
	output reg [6:0] BRAKE_STRENGTH,
	output reg [4:0] JOG_SPEED,
	output reg JOG_REVERSE_DIR
);

	localparam [7:0] S_IDLE = 8'h01, S_RUN = 8'h02;
	localparam [7:0] S_RAMP = 8'h04, S_VEC = 8'h08;
	localparam [7:0] S_RDLY = 8'h10, S_RBRK = 8'h20;
	localparam [7:0] S_DC = 8'h40, S_JOG = 8'h80;
	localparam [23:0] TICK_LAST = TICK_CYCLES - 1;

	function [6:0] clamp7;
		input [6:0] v;
		input [6:0] lo;
		input [6:0] hi;
		begin
			clamp7 = (v < lo) ? lo : ((v > hi) ? hi : v);
		end
	endfunction

	function mapped;
		input [7:0] a;
		begin
			mapped = (a == `OFS_CTRL) || (a == `OFS_LEVEL) || (a == `OFS_STIME) ||
				(a == `OFS_RDLY) || (a == `OFS_JOG) || (a == `OFS_STAT);
		end
	endfunction

	reg [2:0] meth_r;
	reg bmeth_r, perm_fwd_r, perm_rev_r, sens_en_r, tick_r;
	reg [6:0] step_r, bstr_r, dcstr_r, swspd_r, stime_r, jfwd_r, jrev_r, rate_r;
	reg [10:0] rdly_r;
	reg [23:0] div_r;
	reg [7:0] state_r, state_nxt;
	reg [10:0] timer_r, timer_nxt, acc_r, acc_nxt;
	reg [6:0] level_r, level_nxt, rcnt_r, rcnt_nxt;
	reg [4:0] jspd_r, jspd_nxt;
	reg jdir_r, jdir_nxt, revp_r, revp_nxt, fwd_nxt, rev_nxt;
	reg [31:0] rd_nxt;

	wire access = PSEL && PENABLE && PREADY;
	wire wr = access && PWRITE && mapped(PADDR);
	wire [10:0] stop_total = {4'h0, stime_r} * `TICKS_PER_S;
	wire timeout = (timer_r >= stop_total);
	wire low_speed = (SPEED_PCT < swspd_r);
	wire [6:0] span = (meth_r == `SM_VOLT) ? step_r : `FULL_LEVEL;
	wire [11:0] acc_sum = {1'b0, acc_r} + {5'h00, span};
	wire jog_hold = jdir_r ? JOG_REVERSE_INPUT : JOG_FORWARD_INPUT;
	wire [4:0] jog_ref = jog_hold ? (jdir_r ? jrev_r[4:0] : jfwd_r[4:0]) : 5'h00;

	// Time base of 0.1 s; every stop, delay and jog count runs on it
	always @(posedge MCLK) begin
		if (!NRST) begin
			div_r <= 24'h000000;
			tick_r <= 1'b0;
		end else begin
			tick_r <= (div_r == TICK_LAST);
			div_r <= (div_r == TICK_LAST) ? 24'h000000 : div_r + 24'h000001;
		end
	end

	// APB: one wait state, writes land on the completing edge
	always @(posedge MCLK) begin
		if (!NRST) begin
			PREADY <= 1'b0;
			PRDATA <= 32'h00000000;
			PSLVERR <= 1'b0;
			meth_r <= `RST_METH;
			bmeth_r <= `RST_BMETH;
			perm_fwd_r <= 1'b1;
			perm_rev_r <= 1'b1;
			sens_en_r <= 1'b0;
			step_r <= `RST_STEP;
			bstr_r <= `RST_BSTR;
			dcstr_r <= `RST_DCSTR;
			swspd_r <= `RST_SWSPD;
			stime_r <= `RST_STIME;
			rdly_r <= `RST_RDLY;
			jfwd_r <= `RST_JSPD;
			jrev_r <= `RST_JSPD;
			rate_r <= `RST_RATE;
		end else begin
			PREADY <= PSEL && PENABLE && !PREADY;
			PSLVERR <= PSEL && PENABLE && !PREADY && !mapped(PADDR);
			if (PSEL && PENABLE && !PREADY) begin
				PRDATA <= rd_nxt;
			end
			if (wr && PADDR == `OFS_CTRL) begin
				meth_r <= PWDATA[`F_METH]; // see R18
				bmeth_r <= PWDATA[`F_BMETH]; // see R2
				perm_fwd_r <= PWDATA[`F_PERM_FWD];
				perm_rev_r <= PWDATA[`F_PERM_REV];
				sens_en_r <= PWDATA[`F_SENS_EN];
			end
			if (wr && PADDR == `OFS_LEVEL) begin
				step_r <= clamp7(PWDATA[`F_STEP], `MIN_PCT, `MAX_PCT); // see R1
				bstr_r <= clamp7(PWDATA[`F_BSTR], `MIN_BSTR, `MAX_PCT); // see R10
				dcstr_r <= clamp7(PWDATA[`F_DCSTR], `MIN_DCSW, `MAX_DCSW); // see R11
				swspd_r <= clamp7(PWDATA[`F_SWSPD], `MIN_DCSW, `MAX_DCSW); // see R12
			end
			if (wr && PADDR == `OFS_STIME) begin
				stime_r <= clamp7(PWDATA[`F_STIME], `MIN_PCT, `MAX_STIME); // see R9
			end
			if (wr && PADDR == `OFS_RDLY) begin
				rdly_r <= (PWDATA[`F_RDLY] > `MAX_RDLY) ? `MAX_RDLY : PWDATA[`F_RDLY]; // see R5
			end
			if (wr && PADDR == `OFS_JOG) begin
				jfwd_r <= clamp7(PWDATA[`F_JFWD], `MIN_JSPD, `MAX_JSPD); // see R16
				jrev_r <= clamp7(PWDATA[`F_JREV], `MIN_JSPD, `MAX_JSPD); // see R16
				rate_r <= clamp7(PWDATA[`F_RATE], `MIN_RATE, `MAX_PCT); // see R17
			end
		end
	end

	always @* begin
		rd_nxt = 32'h00000000;
		case (PADDR)
			`OFS_CTRL: begin
				rd_nxt[`F_METH] = meth_r;
				rd_nxt[`F_BMETH] = bmeth_r;
				rd_nxt[`F_PERM_FWD] = perm_fwd_r;
				rd_nxt[`F_PERM_REV] = perm_rev_r;
				rd_nxt[`F_SENS_EN] = sens_en_r;
			end
			`OFS_LEVEL: begin
				rd_nxt[`F_STEP] = step_r;
				rd_nxt[`F_BSTR] = bstr_r;
				rd_nxt[`F_DCSTR] = dcstr_r;
				rd_nxt[`F_SWSPD] = swspd_r;
			end
			`OFS_STIME: rd_nxt[`F_STIME] = stime_r;
			`OFS_RDLY: rd_nxt[`F_RDLY] = rdly_r;
			`OFS_JOG: begin
				rd_nxt[`F_JFWD] = jfwd_r;
				rd_nxt[`F_JREV] = jrev_r;
				rd_nxt[`F_RATE] = rate_r;
			end
			`OFS_STAT: rd_nxt = {7'h00, revp_r, jdir_r, jspd_r, level_r, timer_r[10:8], state_r};
			default: rd_nxt = 32'h00000000;
		endcase
	end

	// Sequencer
	always @* begin
		state_nxt = state_r;
		timer_nxt = timer_r;
		acc_nxt = acc_r;
		level_nxt = level_r;
		rcnt_nxt = rcnt_r;
		jspd_nxt = jspd_r;
		jdir_nxt = jdir_r;
		revp_nxt = revp_r;
		if (tick_r && state_r != S_IDLE && state_r != S_RUN && state_r != S_JOG) begin
			timer_nxt = timer_r + 11'h001;
		end
		case (state_r)
			S_IDLE: begin
				timer_nxt = 11'h000;
				acc_nxt = 11'h000;
				revp_nxt = 1'b0;
				jspd_nxt = 5'h00;
				rcnt_nxt = 7'h00;
				level_nxt = `MIN_LEVEL;
				if (RUN_CMD) begin
					state_nxt = S_RUN;
					level_nxt = `FULL_LEVEL;
				end else if (JOG_FORWARD_INPUT && perm_fwd_r) begin // see R13, R14
					state_nxt = S_JOG;
					jdir_nxt = 1'b0;
				end else if (JOG_REVERSE_INPUT && perm_rev_r) begin // see R13, R14
					state_nxt = S_JOG;
					jdir_nxt = 1'b1;
				end
			end
			S_RUN: begin
				timer_nxt = 11'h000;
				acc_nxt = 11'h000;
				if (!RUN_CMD) begin
					case (meth_r)
						`SM_LIN, `SM_SQR: begin
							state_nxt = S_RAMP;
						end
						`SM_VOLT: begin
							state_nxt = S_RAMP;
							level_nxt = step_r; // see R1
						end
						`SM_BRAKE: begin
							if (bmeth_r == `BM_REVERSE) begin // see R2
								state_nxt = S_RDLY; // see R4
								revp_nxt = 1'b1;
							end else begin
								state_nxt = low_speed ? S_DC : S_VEC; // see R3
							end
						end
						default: state_nxt = S_IDLE;
					endcase
				end
			end
			S_RAMP: begin
				// Only one step per tick, so a span larger than the stop time in ticks
				// ramps slower than linear and is cut short by the timeout
				if (timeout) begin // see R9
					state_nxt = S_IDLE;
				end else if (tick_r) begin
					if (acc_sum >= {1'b0, stop_total}) begin // see R1
						acc_nxt = acc_sum[10:0] - stop_total;
						level_nxt = (level_r > `MIN_LEVEL) ? level_r - 7'h01 : `MIN_LEVEL;
					end else begin
						acc_nxt = acc_sum[10:0];
					end
				end
			end
			S_VEC: begin
				if (timeout) begin // see R9
					state_nxt = S_IDLE;
				end else if (low_speed) begin
					state_nxt = S_DC; // see R3
				end
			end
			S_RDLY: begin
				// The delay counts whole ticks, so it may run up to one tick long
				if (tick_r) begin
					acc_nxt = acc_r + 11'h001;
				end
				if (timeout) begin // see R9
					state_nxt = S_IDLE;
				end else if ((rdly_r == 11'h000) || (acc_r > rdly_r)) begin
					state_nxt = S_RBRK; // see R5
				end
			end
			S_RBRK: begin
				if (timeout) begin // see R9
					state_nxt = S_IDLE;
				end else if (low_speed) begin
					state_nxt = S_DC; // see R6
				end
			end
			S_DC: begin
				if (timeout || MOTOR_STOPPED || (sens_en_r && ROT_SENSOR_STOP)) begin // see R8
					state_nxt = S_IDLE;
				end
			end
			S_JOG: begin
				if (tick_r) begin
					if (rcnt_r + 7'h01 >= rate_r) begin // see R17
						rcnt_nxt = 7'h00;
						if (jspd_r < jog_ref) begin
							jspd_nxt = jspd_r + 5'h01;
						end else if (jspd_r > jog_ref) begin
							jspd_nxt = jspd_r - 5'h01;
						end
					end else begin
						rcnt_nxt = rcnt_r + 7'h01;
					end
				end
				if (!jog_hold && jspd_r == 5'h00) begin
					state_nxt = S_IDLE;
				end
			end
			default: state_nxt = S_IDLE;
		endcase
		fwd_nxt = (state_nxt != S_IDLE) && !revp_nxt; // see R4
		// A cycle with both contactors open is forced even at zero delay
		rev_nxt = (state_nxt == S_RBRK || (state_nxt == S_DC && revp_nxt)) &&
			!fwd_nxt && !FORWARD_RUN_RELAY; // see R19
	end

	always @(posedge MCLK) begin
		if (!NRST) begin
			state_r <= S_IDLE;
			timer_r <= 11'h000;
			acc_r <= 11'h000;
			level_r <= `MIN_LEVEL;
			rcnt_r <= 7'h00;
			jspd_r <= 5'h00;
			jdir_r <= 1'b0;
			revp_r <= 1'b0;
			FORWARD_RUN_RELAY <= 1'b0;
			REVERSE_BRAKE_RELAY <= 1'b0;
			FORWARD_OPERATION_RELAY_FN <= 1'b0;
			VOLT_LEVEL <= `MIN_LEVEL;
			PHASE_EN <= `PH_OFF;
			VECTOR_BRAKE_ACTIVE <= 1'b0;
			DC_BRAKE_ACTIVE <= 1'b0;
			BRAKE_STRENGTH <= `MIN_PCT;
			JOG_SPEED <= 5'h00;
			JOG_REVERSE_DIR <= 1'b0;
		end else begin
			state_r <= state_nxt;
			timer_r <= timer_nxt;
			acc_r <= acc_nxt;
			level_r <= level_nxt;
			rcnt_r <= rcnt_nxt;
			jspd_r <= jspd_nxt;
			jdir_r <= jdir_nxt;
			revp_r <= revp_nxt;
			FORWARD_RUN_RELAY <= fwd_nxt;
			REVERSE_BRAKE_RELAY <= rev_nxt; // see R5, R19
			FORWARD_OPERATION_RELAY_FN <= (state_nxt == S_RUN) || (state_nxt == S_JOG); // see R15
			VOLT_LEVEL <= (state_nxt == S_RAMP || state_nxt == S_RUN) ? level_nxt : `MIN_LEVEL;
			PHASE_EN <= (state_nxt == S_DC) ? `PH_DC : // see R7
				((state_nxt == S_IDLE || state_nxt == S_RDLY) ? `PH_OFF : `PH_ALL);
			VECTOR_BRAKE_ACTIVE <= (state_nxt == S_VEC); // see R3
			DC_BRAKE_ACTIVE <= (state_nxt == S_DC);
			BRAKE_STRENGTH <= (state_nxt == S_VEC || state_nxt == S_RBRK) ? bstr_r : // see R10
				((state_nxt == S_DC) ? dcstr_r : `MIN_PCT); // see R11
			JOG_SPEED <= jspd_nxt; // see R16
			JOG_REVERSE_DIR <= (state_nxt == S_JOG) && jdir_nxt; // see R15
		end
	end

endmodule // motor_stop_brake_jog_sequencer

// ---- core/stop_seq_defines.vh ----
`ifndef STOP_SEQ_DEFINES_VH
`define STOP_SEQ_DEFINES_VH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_LEVEL 8'h04
`define OFS_STIME 8'h08
`define OFS_RDLY 8'h0c
`define OFS_JOG 8'h10
`define OFS_STAT 8'h14

// Field positions
`define F_METH 2:0
`define F_BMETH 3
`define F_PERM_FWD 4
`define F_PERM_REV 5
`define F_SENS_EN 6
`define F_STEP 6:0
`define F_BSTR 14:8
`define F_DCSTR 22:16
`define F_SWSPD 30:24
`define F_STIME 6:0
`define F_RDLY 10:0
`define F_JFWD 6:0
`define F_JREV 14:8
`define F_RATE 22:16

// Stop and brake method codes
`define SM_LIN 3'h1
`define SM_SQR 3'h2
`define SM_VOLT 3'h3
`define SM_COAST 3'h4
`define SM_BRAKE 3'h5
`define BM_VECTOR 1'b0
`define BM_REVERSE 1'b1

// Reset values
`define RST_METH 3'h4
`define RST_BMETH 1'b0
`define RST_STEP 7'h64
`define RST_BSTR 7'h4b
`define RST_DCSTR 7'h1e
`define RST_SWSPD 7'h1e
`define RST_STIME 7'h0a
`define RST_RDLY 11'h005
`define RST_JSPD 7'h0a
`define RST_RATE 7'h02

// Settable ranges
`define MIN_PCT 7'h00
`define MAX_PCT 7'h64
`define MIN_BSTR 7'h14
`define MIN_DCSW 7'h14
`define MAX_DCSW 7'h50
`define MAX_STIME 7'h78
`define MAX_RDLY 11'h4b0
`define MIN_JSPD 7'h01
`define MAX_JSPD 7'h1e
`define MIN_RATE 7'h01

// Output levels
`define FULL_LEVEL 7'h64
`define MIN_LEVEL 7'h00
`define PH_ALL 3'b111
`define PH_DC 3'b110
`define PH_OFF 3'b000

// Timing
`define CLK_FREQ_KHZ 125000
`define TICK_TIME_MS 100
`define TICKS_PER_S 11'd10

`endif

// ---- tb/stop_seq_properties.sv ----
`timescale 1ns/1ps
module stop_seq_checker (
	// Clock and reset
	input wire MCLK,
	input wire NRST,
	// Watched outputs and feedback
	input wire PREADY,
	input wire [6:0] SPEED_PCT,
	input wire MOTOR_STOPPED,
	input wire FORWARD_RUN_RELAY,
	input wire REVERSE_BRAKE_RELAY,
	input wire FORWARD_OPERATION_RELAY_FN,
	input wire [6:0] VOLT_LEVEL,
	input wire [2:0] PHASE_EN,
	input wire VECTOR_BRAKE_ACTIVE,
	input wire DC_BRAKE_ACTIVE,
	input wire [6:0] BRAKE_STRENGTH,
	input wire [4:0] JOG_SPEED
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!NRST);
	interlock_a: assert property (!(FORWARD_RUN_RELAY && REVERSE_BRAKE_RELAY))
		else $error("both contactors on");
	rev_gap_a: assert property ($rose(REVERSE_BRAKE_RELAY) |-> !$past(FORWARD_RUN_RELAY))
		else $error("reverse contactor without gap");
	dc_phases_a: assert property (DC_BRAKE_ACTIVE |-> PHASE_EN == 3'b110
		&& BRAKE_STRENGTH >= 7'h14 && BRAKE_STRENGTH <= 7'h50)
		else $error("bad dc brake drive");
	vector_drive_a: assert property (VECTOR_BRAKE_ACTIVE |-> !DC_BRAKE_ACTIVE
		&& PHASE_EN == 3'b111 && BRAKE_STRENGTH >= 7'h14)
		else $error("bad vector brake drive");
	// Threshold is never below 20, so slower speeds must always leave the fast brake
	slow_to_dc_a: assert property ((VECTOR_BRAKE_ACTIVE || (REVERSE_BRAKE_RELAY
		&& !DC_BRAKE_ACTIVE)) && SPEED_PCT < 7'h14 |=> PHASE_EN != 3'b111)
		else $error("fast brake kept at low speed");
	dc_stop_end_a: assert property (DC_BRAKE_ACTIVE && MOTOR_STOPPED |=> !DC_BRAKE_ACTIVE)
		else $error("dc brake kept at standstill");
	both_off_a: assert property (!FORWARD_RUN_RELAY && !REVERSE_BRAKE_RELAY
		|-> PHASE_EN == 3'b000)
		else $error("phases driven with contactors open");
	volt_ramp_a: assert property (VOLT_LEVEL != 7'h0 && $past(VOLT_LEVEL) != 7'h0
		&& !$past(FORWARD_OPERATION_RELAY_FN) |-> VOLT_LEVEL == $past(VOLT_LEVEL)
		|| VOLT_LEVEL == $past(VOLT_LEVEL) - 7'h1)
		else $error("stop ramp not monotonic");
	jog_relay_a: assert property (JOG_SPEED != 5'h0 |-> FORWARD_OPERATION_RELAY_FN
		&& JOG_SPEED <= 5'h1e)
		else $error("jog without forward operation");
	// Step hold assumes a tick period of nine cycles or more
	jog_step_a: assert property ($changed(JOG_SPEED) |-> (JOG_SPEED == $past(JOG_SPEED) + 5'h1
		|| JOG_SPEED == $past(JOG_SPEED) - 5'h1) ##1 $stable(JOG_SPEED) [*8])
		else $error("jog speed jumped");
	pready_pulse_a: assert property (PREADY |=> !PREADY)
		else $error("ready held");
endmodule // stop_seq_checker

bind motor_stop_brake_jog_sequencer stop_seq_checker chk (.MCLK, .NRST, .PREADY, .SPEED_PCT,
	.MOTOR_STOPPED, .FORWARD_RUN_RELAY, .REVERSE_BRAKE_RELAY, .FORWARD_OPERATION_RELAY_FN,
	.VOLT_LEVEL, .PHASE_EN, .VECTOR_BRAKE_ACTIVE, .DC_BRAKE_ACTIVE, .BRAKE_STRENGTH, .JOG_SPEED);

// ---- tb/motor_far_side.sv ----
`timescale 1ns/1ps
module motor_far_side (
	// Clock
	input wire logic clk,
	// Drive seen by the motor
	input wire logic [2:0] phase_en,
	input wire logic braking,
	input wire logic stuck,
	// Feedback
	output logic [6:0] speed = 7'h0,
	output logic stopped
);
	// Spins up to 80 under full drive, slows one step a cycle while braked unless stuck; no free-run decay
	always @(posedge clk) begin
		if (phase_en == 3'b111 && !braking && speed < 7'h50)
			speed <= speed + 7'h1;
		else if (braking && !stuck && speed != 7'h0)
			speed <= speed - 7'h1;
	end
	assign stopped = (speed == 7'h0);
endmodule // motor_far_side

// ---- tb/motor_stop_brake_jog_sequencer_tb.sv ----
`timescale 1ns/1ps
`include "stop_seq_defines.vh"
module motor_stop_brake_jog_sequencer_tb;
	logic mclk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, run = 1'b0, jf = 1'b0, jr = 1'b0, sens = 1'b0, stuck = 1'b0;
	logic stopped, fwd, rev, opr, vec, dc, jdir;
	logic [6:0] speed, volt, bstr;
	logic [2:0] ph;
	logic [4:0] jspd;
	int n_fail = 0, n_compared = 0, k;
	typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} row_t;
	row_t rows[10] = '{'{1'b0, `OFS_CTRL, 32'h0, 32'h34, 1'b0},
		'{1'b0, `OFS_LEVEL, 32'h0, 32'h1e1e4b64, 1'b0}, '{1'b0, `OFS_STIME, 32'h0, 32'ha, 1'b0},
		'{1'b0, `OFS_RDLY, 32'h0, 32'h5, 1'b0}, '{1'b0, `OFS_JOG, 32'h0, 32'h20a0a, 1'b0},
		'{1'b0, `OFS_STAT, 32'h0, 32'h1, 1'b0}, '{1'b1, 8'h18, 32'h1, 32'h0, 1'b1},
		'{1'b1, `OFS_LEVEL, 32'h5a5a057f, 32'h50501464, 1'b0},
		'{1'b1, `OFS_STIME, 32'h7f, 32'h78, 1'b0}, '{1'b1, `OFS_JOG, 32'h2800, 32'h11e01, 1'b0}};
	logic [6:0] exp_v[1:5] = '{7'h64, 7'h64, 7'h3c, 7'h0, 7'h0};
	logic [6:0] exp_b[1:5] = '{7'h0, 7'h0, 7'h0, 7'h0, 7'h4b};
	logic [2:0] exp_ph[1:5] = '{3'h7, 3'h7, 3'h7, 3'h0, 3'h7};

	always #4 mclk = ~mclk;

	motor_stop_brake_jog_sequencer #(.TICK_CYCLES(10)) uut (.MCLK(mclk), .NRST(nrst),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .RUN_CMD(run),
		.JOG_FORWARD_INPUT(jf), .JOG_REVERSE_INPUT(jr), .SPEED_PCT(speed),
		.MOTOR_STOPPED(stopped), .ROT_SENSOR_STOP(sens), .FORWARD_RUN_RELAY(fwd),
		.REVERSE_BRAKE_RELAY(rev), .FORWARD_OPERATION_RELAY_FN(opr), .VOLT_LEVEL(volt),
		.PHASE_EN(ph), .VECTOR_BRAKE_ACTIVE(vec), .DC_BRAKE_ACTIVE(dc),
		.BRAKE_STRENGTH(bstr), .JOG_SPEED(jspd), .JOG_REVERSE_DIR(jdir));
	motor_far_side motor (.clk(mclk), .phase_en(ph), .braking(vec | dc | rev), .stuck(stuck),
		.speed(speed), .stopped(stopped));

	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		i = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 20) begin
			n_fail++;
			tally_and_finish;
		end
	endtask

	// Bounded wait for the phase pattern; k holds the cycles spent
	task automatic wait_ph(input logic [2:0] v, input int n);
		k = 0;
		while (ph !== v && k < n) begin
			@(posedge mclk);
			k++;
		end
		if (k == n) begin
			n_fail++;
			tally_and_finish;
		end
	endtask

	task automatic stop_run(input int c);
		run <= 1'b1;
		repeat (c) @(posedge mclk);
		run <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask

	initial begin
		repeat (16) @(posedge mclk);
		nrst <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].w)
				apb(1'b1, rows[i].a, rows[i].d);
			apb(1'b0, rows[i].a, 32'h0);
			chk(rd, rows[i].q);
			chk(err, rows[i].e);
		end
		apb(1'b1, `OFS_LEVEL, 32'h1e1e4b3c);
		apb(1'b1, `OFS_STIME, 32'h2);
		apb(1'b1, `OFS_JOG, 32'h10305);
		for (int m = 1; m <= 5; m++) begin
			apb(1'b1, `OFS_CTRL, 32'h30 | m);
			stop_run(100);
			chk(ph, exp_ph[m]);
			chk(volt, exp_v[m]);
			chk(bstr, exp_b[m]);
			chk(vec, m == 5);
			wait_ph(3'b000, 260);
			if (m == 3)
				chk(k > 185 && k < 215, 1'b1);
		end
		stuck <= 1'b1;
		stop_run(100);
		wait_ph(3'b000, 260);
		chk(k > 185 && k < 215, 1'b1);
		stuck <= 1'b0;
		for (int d = 3; d >= 0; d -= 3) begin
			apb(1'b1, `OFS_RDLY, 32'(d));
			apb(1'b1, `OFS_CTRL, 32'h3d);
			stop_run(100);
			chk({fwd, rev}, 2'b00);
			wait_ph(3'b111, 60);
			chk(k >= d * 10 && k <= d * 10 + 12, 1'b1);
			wait_ph(3'b110, 100);
			chk({fwd, rev, dc, bstr}, {3'b011, 7'h1e});
			wait_ph(3'b000, 200);
		end
		apb(1'b1, `OFS_CTRL, 32'h75);
		stop_run(100);
		wait_ph(3'b110, 100);
		stuck <= 1'b1;
		sens <= 1'b1;
		repeat (2) @(posedge mclk);
		chk(ph, 3'b000);
		{stuck, sens} <= 2'b00;
		apb(1'b1, `OFS_CTRL, 32'h34);
		jf <= 1'b1;
		repeat (25) @(posedge mclk);
		chk(jspd > 5'h0 && jspd < 5'h5, 1'b1);
		repeat (55) @(posedge mclk);
		chk({opr, jdir, jspd}, {2'b10, 5'h5});
		jf <= 1'b0;
		wait_ph(3'b000, 100);
		jr <= 1'b1;
		repeat (60) @(posedge mclk);
		chk({opr, jdir, jspd}, {2'b11, 5'h3});
		jr <= 1'b0;
		wait_ph(3'b000, 100);
		apb(1'b1, `OFS_CTRL, 32'h14);
		jr <= 1'b1;
		repeat (20) @(posedge mclk);
		chk({ph, opr}, 4'h0);
		// Reset in the middle of a jog must drop forward contactor, operation relay, phases and jog speed and restore the control register default
		jf <= 1'b1;
		repeat (30) @(posedge mclk);
		nrst <= 1'b0;
		repeat (2) @(posedge mclk);
		chk({fwd, opr, ph, jspd}, 10'h0);
		nrst <= 1'b1;
		{jf, jr} <= 2'b00;
		apb(1'b0, `OFS_CTRL, 32'h0);
		chk(rd, 32'h34);
		tally_and_finish;
	end
endmodule // motor_stop_brake_jog_sequencer_tb
